// ===== src/wait_pkg.sv
/*
 Shared constants for the bus wait-state controller: register addresses,
 field positions, reset values, cycle kinds and bus states.
 Assumes a 10 MHz processor clock and a 20-bit memory address space.
*/
`default_nettype none
package wait_pkg;
   // Register addresses in the system I/O area
   localparam logic [15:0] ADDR_REFRESH_DMA = 16'hfff6;
   localparam logic [15:0] ADDR_AREA        = 16'hffe0;
   localparam logic [15:0] ADDR_SPLIT       = 16'hffe1;
   localparam logic [15:0] ADDR_SUB         = 16'hffe2;
   localparam logic [15:0] ADDR_IOB         = 16'hffe3;
   localparam logic [15:0] ADDR_WCY_A       = 16'hffe4;
   localparam logic [15:0] ADDR_WCY_C       = 16'hffe5;
   localparam logic [15:0] ADDR_STATUS      = 16'hffe7;
   // Writable bits; unused bits read as zero
   localparam logic [7:0] MASK_AREA  = 8'h77;
   localparam logic [7:0] MASK_SPLIT = 8'h07;
   localparam logic [7:0] MASK_SUB   = 8'h33;
   localparam logic [7:0] MASK_IOB   = 8'h77;
   localparam logic [7:0] MASK_WCY_B = 8'h0f;
   localparam logic [7:0] MASK_WCY   = 8'hff;
   // Values after reset: slowest setting until software tunes it
   localparam logic [7:0] RST_AREA  = 8'h00;
   localparam logic [7:0] RST_SPLIT = 8'h00;
   localparam logic [7:0] RST_SUB   = 8'h00;
   localparam logic [7:0] RST_IOB   = 8'h00;
   localparam logic [7:0] RST_WCY   = 8'hff;
   localparam logic [7:0] RST_WCY_B = 8'h0f;
   // Field positions
   localparam int LOWER_BOUND_LSB = 0;
   localparam int UPPER_BOUND_LSB = 4;
   localparam int LOWER_SPLIT_BIT = 0;
   localparam int UPPER_SPLIT_BIT = 1;
   localparam int IO_SPLIT_BIT    = 2;
   localparam int LOWER_SUB_LSB   = 0;
   localparam int UPPER_SUB_LSB   = 4;
   localparam int LOWER_IO_LSB    = 0;
   localparam int UPPER_IO_LSB    = 4;
   localparam int WA_LOWER_LSB    = 0;
   localparam int WA_MIDDLE_LSB   = 2;
   localparam int WA_UPPER_LSB    = 4;
   localparam int WA_MID_IO_LSB   = 6;
   localparam int WB_REFRESH_LSB  = 0;
   localparam int WB_DMA_LSB      = 2;
   localparam int WC_LOWER_IO_LSB = 0;
   localparam int WC_UPPER_IO_LSB = 2;
   localparam int WC_LOWER_SUB_LSB = 4;
   localparam int WC_UPPER_SUB_LSB = 6;
   // Space sizes and size units
   localparam logic [20:0] MEM_TOP  = 21'h100000;
   localparam logic [20:0] SUB_UNIT = 21'h004000;
   localparam logic [16:0] IO_TOP   = 17'h10000;
   localparam logic [16:0] IO_UNIT  = 17'h00100;
   localparam logic [1:0]  MAX_WAITS = 2'h3;

   typedef enum logic [2:0] {
      KIND_MEM     = 3'h0,
      KIND_EXT_IO  = 3'h1,
      KIND_INT_IO  = 3'h2,
      KIND_DMA     = 3'h3,
      KIND_REFRESH = 3'h4
   } cycle_kind_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_T1   = 3'h1,
      ST_T2   = 3'h2,
      ST_T3   = 3'h3,
      ST_TW   = 3'h4,
      ST_T4   = 3'h5
   } bus_state_t;
endpackage
`default_nettype wire

// ===== src/wait_cfg_if.sv
/*
 Carrier between the cycle controller and the wait selector: register
 contents and the current cycle go out, the programmed count comes back.
 Assumes both ends sit in the same clock domain.
*/
`default_nettype none
interface wait_cfg_if;
   logic [7:0]           area;
   logic [7:0]           split;
   logic [7:0]           sub;
   logic [7:0]           iob;
   logic [7:0]           wcy_a;
   logic [7:0]           wcy_b;
   logic [7:0]           wcy_c;
   wait_pkg::cycle_kind_t kind;
   logic [19:0]          addr;
   logic [1:0]           waits;

   modport ctrl (output area, split, sub, iob, wcy_a, wcy_b, wcy_c,
                 output kind, addr, input waits);
   modport sel  (input area, split, sub, iob, wcy_a, wcy_b, wcy_c,
                 input kind, addr, output waits);
endinterface
`default_nettype wire

// ===== src/wait_select.sv
/*
 Programmed wait count for the cycle on the carrier, from block decode for memory and external I/O cycles.
 Assumes software keeps subblocks inside their parent blocks.
*/
`default_nettype none
module wait_select
(
   wait_cfg_if.sel cfg
);
   logic [20:0] mem_a;
   logic [20:0] low_size;
   logic [20:0] up_size;
   logic [20:0] lsub_size;
   logic [20:0] usub_size;
   logic [16:0] io_a;
   logic [16:0] io_low;
   logic [16:0] io_up;

   always_comb
   begin
      mem_a     = {1'b0, cfg.addr};
      low_size  = {2'b00, cfg.area[wait_pkg::LOWER_BOUND_LSB +: 3], 16'h0000};
      up_size   = {2'b00, cfg.area[wait_pkg::UPPER_BOUND_LSB +: 3], 16'h0000};
      lsub_size = wait_pkg::SUB_UNIT << cfg.sub[wait_pkg::LOWER_SUB_LSB +: 2];
      usub_size = wait_pkg::SUB_UNIT << cfg.sub[wait_pkg::UPPER_SUB_LSB +: 2];
      io_a      = {1'b0, cfg.addr[15:0]};
      io_low    = wait_pkg::IO_UNIT << cfg.iob[wait_pkg::LOWER_IO_LSB +: 3];
      io_up     = wait_pkg::IO_UNIT << cfg.iob[wait_pkg::UPPER_IO_LSB +: 3];
      cfg.waits = 2'h0;
      unique case (cfg.kind)
         wait_pkg::KIND_MEM:
         begin
            if (cfg.split[wait_pkg::LOWER_SPLIT_BIT] && mem_a < lsub_size)
               cfg.waits = cfg.wcy_c[wait_pkg::WC_LOWER_SUB_LSB +: 2];
            else if (mem_a < low_size)
               cfg.waits = cfg.wcy_a[wait_pkg::WA_LOWER_LSB +: 2];
            else if (cfg.split[wait_pkg::UPPER_SPLIT_BIT]
                     && mem_a >= wait_pkg::MEM_TOP - usub_size)
               cfg.waits = cfg.wcy_c[wait_pkg::WC_UPPER_SUB_LSB +: 2];
            else if (mem_a >= wait_pkg::MEM_TOP - up_size)
               cfg.waits = cfg.wcy_a[wait_pkg::WA_UPPER_LSB +: 2];
            else
               cfg.waits = cfg.wcy_a[wait_pkg::WA_MIDDLE_LSB +: 2];
         end
         wait_pkg::KIND_EXT_IO:
         begin
            // three I/O blocks only when split
            if (cfg.split[wait_pkg::IO_SPLIT_BIT] && io_a < io_low)
               cfg.waits = cfg.wcy_c[wait_pkg::WC_LOWER_IO_LSB +: 2];
            else if (cfg.split[wait_pkg::IO_SPLIT_BIT]
                     && io_a >= wait_pkg::IO_TOP - io_up)
               cfg.waits = cfg.wcy_c[wait_pkg::WC_UPPER_IO_LSB +: 2];
            else
               cfg.waits = cfg.wcy_a[wait_pkg::WA_MID_IO_LSB +: 2];
         end
         // one count per DMA or refresh
         wait_pkg::KIND_DMA:
            cfg.waits = cfg.wcy_b[wait_pkg::WB_DMA_LSB +: 2];
         wait_pkg::KIND_REFRESH:
            cfg.waits = cfg.wcy_b[wait_pkg::WB_REFRESH_LSB +: 2];
         default:
            cfg.waits = 2'h0;
      endcase
   end
endmodule
`default_nettype wire

// ===== src/bus_wait_state_control.sv
/*
 Bus wait-state controller: sequences each bus cycle through its states,
 adds waits from the ready pin and from the programmed counts, and holds
 the wait configuration registers on the internal I/O port.
 Assumes the processor pulses cycle_start in idle or in the fourth state,
 and that ready_pin is asynchronous to clk.
*/
`default_nettype none

module bus_wait_state_control
(
   input  wire logic                  clk,
   input  wire logic                  reset_n,
   input  wire logic                  ready_pin,
   input  wire logic                  cycle_start,
   input  wire wait_pkg::cycle_kind_t cycle_kind,
   input  wire logic [19:0]           cycle_addr,
   input  wire logic [15:0]           io_addr,
   input  wire logic                  io_wr,
   input  wire logic                  io_rd,
   input  wire logic [7:0]            io_wdata,
   output logic [7:0]                 io_rdata,
   output logic                       io_rdata_valid,
   output logic                       io_hit,
   output wait_pkg::bus_state_t       bus_state,
   output logic                       wait_state,
   output logic                       cycle_end
);
   typedef struct packed {
      logic [7:0]            area;
      logic [7:0]            split;
      logic [7:0]            sub;
      logic [7:0]            iob;
      logic [7:0]            wcy_a;
      logic [7:0]            wcy_b;
      logic [7:0]            wcy_c;
      logic [7:0]            rdata;
      logic                  rvalid;
      logic [2:0]            sync;
      logic                  ready_lvl;
      wait_pkg::bus_state_t  st;
      wait_pkg::cycle_kind_t kind;
      logic [19:0]           addr;
      logic                  chain;
      logic [1:0]            tw_cnt;
      logic [1:0]            prog;
      logic                  end_p;
   } state_t;

   state_t     q;
   state_t     d;
   wait_cfg_if cfg ();
   logic       uses_ready;
   logic       need_wait;
   logic       hit;

   assign cfg.area  = q.area;
   assign cfg.split = q.split;
   assign cfg.sub   = q.sub;
   assign cfg.iob   = q.iob;
   assign cfg.wcy_a = q.wcy_a;
   assign cfg.wcy_b = q.wcy_b;
   assign cfg.wcy_c = q.wcy_c;
   assign cfg.kind  = q.kind;
   assign cfg.addr  = q.addr;

   wait_select u_select
   (
      .cfg (cfg.sel)
   );

   // Address decode of the configuration port
   always_comb
   begin
      unique case (io_addr)
         wait_pkg::ADDR_REFRESH_DMA,
         wait_pkg::ADDR_AREA,
         wait_pkg::ADDR_SPLIT,
         wait_pkg::ADDR_SUB,
         wait_pkg::ADDR_IOB,
         wait_pkg::ADDR_WCY_A,
         wait_pkg::ADDR_WCY_C,
         wait_pkg::ADDR_STATUS:
            hit = 1'b1;
         default:
            hit = 1'b0;
      endcase
   end

   // internal I/O cycles never look at ready
   assign uses_ready = (q.kind != wait_pkg::KIND_INT_IO);

   // wait while either source still asks
   assign need_wait = q.chain || (q.tw_cnt < q.prog);

   always_comb
   begin
      d        = q;
      d.end_p  = 1'b0;
      d.rvalid = 1'b0;

      // Ready filter: only the second stage reads the first
      d.sync[0] = ready_pin;
      d.sync[1] = q.sync[0];
      d.sync[2] = q.sync[1];
      if (q.sync[1] == q.sync[2])
         d.ready_lvl = q.sync[2];

      // unused bits dropped; software writes them as zero
      // two-bit wait fields kept as written
      if (io_wr)
      begin
         unique case (io_addr)
            wait_pkg::ADDR_REFRESH_DMA:
               d.wcy_b = io_wdata & wait_pkg::MASK_WCY_B;
            wait_pkg::ADDR_AREA:
               d.area = io_wdata & wait_pkg::MASK_AREA;
            wait_pkg::ADDR_SPLIT:
               d.split = io_wdata & wait_pkg::MASK_SPLIT;
            // sizes taken as given, not clipped
            wait_pkg::ADDR_SUB:
               d.sub = io_wdata & wait_pkg::MASK_SUB;
            wait_pkg::ADDR_IOB:
               d.iob = io_wdata & wait_pkg::MASK_IOB;
            // memory blocks and middle I/O block
            wait_pkg::ADDR_WCY_A:
               d.wcy_a = io_wdata & wait_pkg::MASK_WCY;
            wait_pkg::ADDR_WCY_C:
               d.wcy_c = io_wdata & wait_pkg::MASK_WCY;
            default:
               d.area = q.area;
         endcase
      end

      // Read data one cycle after the strobe; unmapped reads zero
      if (io_rd)
      begin
         d.rvalid = 1'b1;
         unique case (io_addr)
            wait_pkg::ADDR_REFRESH_DMA:
               d.rdata = q.wcy_b;
            wait_pkg::ADDR_AREA:
               d.rdata = q.area;
            wait_pkg::ADDR_SPLIT:
               d.rdata = q.split;
            wait_pkg::ADDR_SUB:
               d.rdata = q.sub;
            wait_pkg::ADDR_IOB:
               d.rdata = q.iob;
            wait_pkg::ADDR_WCY_A:
               d.rdata = q.wcy_a;
            wait_pkg::ADDR_WCY_C:
               d.rdata = q.wcy_c;
            wait_pkg::ADDR_STATUS:
               d.rdata = {q.ready_lvl, q.chain, q.tw_cnt,
                          1'b0, q.st};
            default:
               d.rdata = 8'h00;
         endcase
      end

      unique case (q.st)
         wait_pkg::ST_IDLE:
         begin
            if (cycle_start)
            begin
               d.st   = wait_pkg::ST_T1;
               d.kind = cycle_kind;
               d.addr = cycle_addr;
            end
         end
         wait_pkg::ST_T1:
         begin
            d.st = wait_pkg::ST_T2;
         end
         wait_pkg::ST_T2:
         begin
            // programmed count fixed for this cycle
            d.prog   = cfg.waits;
            d.tw_cnt = 2'h0;
            // high ready here means no ready waits
            // low ready here asks for the first wait
            d.chain  = uses_ready && !q.ready_lvl;
            d.st     = wait_pkg::ST_T3;
         end
         wait_pkg::ST_T3,
         wait_pkg::ST_TW:
         begin
            // a high sample breaks the chain for good
            d.chain = q.chain && uses_ready && !q.ready_lvl;
            // wait follows the sample two states before
            if (need_wait)
            begin
               d.st = wait_pkg::ST_TW;
               if (q.tw_cnt != wait_pkg::MAX_WAITS)
                  d.tw_cnt = q.tw_cnt + 2'h1;
            end
            else
            begin
               d.st = wait_pkg::ST_T4;
            end
         end
         wait_pkg::ST_T4:
         begin
            // Ready is not sampled here; back-to-back cycles allowed
            d.end_p = 1'b1;
            d.chain = 1'b0;
            if (cycle_start)
            begin
               d.st   = wait_pkg::ST_T1;
               d.kind = cycle_kind;
               d.addr = cycle_addr;
            end
            else
            begin
               d.st = wait_pkg::ST_IDLE;
            end
         end
         default:
         begin
            // Illegal code recovers to idle
            d.st = wait_pkg::ST_IDLE;
         end
      endcase

      if (!reset_n)
      begin
         d.area      = wait_pkg::RST_AREA;
         d.split     = wait_pkg::RST_SPLIT;
         d.sub       = wait_pkg::RST_SUB;
         d.iob       = wait_pkg::RST_IOB;
         d.wcy_a     = wait_pkg::RST_WCY;
         d.wcy_b     = wait_pkg::RST_WCY_B;
         d.wcy_c     = wait_pkg::RST_WCY;
         d.rdata     = 8'h00;
         d.rvalid    = 1'b0;
         d.sync      = 3'h7;
         d.ready_lvl = 1'b1;
         d.st        = wait_pkg::ST_IDLE;
         d.kind      = wait_pkg::KIND_MEM;
         d.addr      = 20'h00000;
         d.chain     = 1'b0;
         d.tw_cnt    = 2'h0;
         d.prog      = 2'h0;
         d.end_p     = 1'b0;
      end
   end

   // Reset folded into the next-state copy keeps one register process
   always_ff @(posedge clk)
   begin
      q <= d;
   end

   assign io_rdata       = q.rdata;
   assign io_rdata_valid = q.rvalid;
   assign io_hit         = hit;
   assign bus_state      = q.st;
   assign wait_state     = (q.st == wait_pkg::ST_TW);
   assign cycle_end      = q.end_p;
endmodule
`default_nettype wire

// ===== verif/bus_wait_asserts.sv
/*
 Port assertions for the bus wait-state controller.
 Assumes it is bound onto the top module by the bench.
*/
`default_nettype none
module bus_wait_asserts
(
   input wire logic                  clk,
   input wire logic                  reset_n,
   input wire logic                  ready_pin,
   input wire logic                  cycle_start,
   input wire wait_pkg::cycle_kind_t cycle_kind,
   input wire logic                  io_rd,
   input wire logic                  io_rdata_valid,
   input wire wait_pkg::bus_state_t  bus_state,
   input wire logic                  wait_state,
   input wire logic                  cycle_end
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0]            low_q;
   logic [3:0]            high_q;
   logic [3:0]            tw_q;
   wait_pkg::cycle_kind_t kind_q;
   logic                  acc;

   assign acc = cycle_start && (bus_state == wait_pkg::ST_IDLE
                || bus_state == wait_pkg::ST_T4);
   // Pin run lengths saturate, so long stalls stay in range
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         low_q  <= 4'h0;
         high_q <= 4'h0;
         tw_q   <= 4'h0;
         kind_q <= wait_pkg::KIND_MEM;
      end
      else
      begin
         low_q  <= ready_pin ? 4'h0 : low_q + {3'h0, low_q != 4'hf};
         high_q <= !ready_pin ? 4'h0 : high_q + {3'h0, high_q != 4'hf};
         tw_q   <= (bus_state == wait_pkg::ST_TW) ? tw_q + 4'h1 : 4'h0;
         if (acc)
            kind_q <= cycle_kind;
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);

   start_t1_a: assert property (acc |=> bus_state == wait_pkg::ST_T1)
      else $error("start not followed by first state");
   early_seq_a: assert property (bus_state == wait_pkg::ST_T1 |=>
      bus_state == wait_pkg::ST_T2 ##1 bus_state == wait_pkg::ST_T3)
      else $error("early states out of order");
   t3_exit_a: assert property (bus_state == wait_pkg::ST_T3 |=>
      bus_state inside {wait_pkg::ST_TW, wait_pkg::ST_T4})
      else $error("bad state after third state");
   tw_exit_a: assert property (bus_state == wait_pkg::ST_TW |=>
      bus_state inside {wait_pkg::ST_TW, wait_pkg::ST_T4})
      else $error("bad state after wait state");
   end_pulse_a: assert property (bus_state == wait_pkg::ST_T4 |=>
      cycle_end ##1 !cycle_end)
      else $error("end pulse wrong");
   wait_flag_a: assert property (wait_state ==
      (bus_state == wait_pkg::ST_TW))
      else $error("wait flag disagrees with state");
   int_io_a: assert property (acc && cycle_kind == wait_pkg::KIND_INT_IO
      |-> ##4 bus_state == wait_pkg::ST_T4)
      else $error("internal cycle was stretched");
   prog_cap_a: assert property (bus_state == wait_pkg::ST_TW
      && high_q == 4'hf |-> tw_q < 4'h3)
      else $error("more than three programmed waits");
   ready_hold_a: assert property (bus_state == wait_pkg::ST_T3
      && low_q >= 4'h5 && kind_q != wait_pkg::KIND_INT_IO
      |=> bus_state == wait_pkg::ST_TW)
      else $error("low ready did not add a wait");
   rd_valid_a: assert property (io_rd |=> io_rdata_valid)
      else $error("read not answered");
endmodule
`default_nettype wire

// ===== verif/ready_device.sv
/*
 Slow external device that drives the ready pin.
 Assumes the bench arms it three clocks before a cycle start.
*/
`default_nettype none
module ready_device
(
   input  wire logic       clk,
   input  wire logic       reset_n,
   input  wire logic       arm,
   input  wire logic [3:0] low_clocks,
   output logic            ready_pin
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] left_q;

   always_ff @(posedge clk)
   begin
      if (!reset_n)
         left_q <= 4'h0;
      else if (arm)
         left_q <= low_clocks;
      else if (left_q != 4'h0)
         left_q <= left_q - 4'h1;
   end
   assign ready_pin = (left_q == 4'h0);
endmodule
`default_nettype wire

// ===== verif/bus_wait_state_control_tb.sv
/*
 Self-checking bench for the wait-state controller.
 Assumes the filtered ready level lags the pin by four clocks.
*/
`default_nettype none
module bus_wait_state_control_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic                  clk = 1'b0;
   logic                  reset_n = 1'b0;
   logic                  ready_pin;
   logic                  cycle_start = 1'b0;
   wait_pkg::cycle_kind_t cycle_kind = wait_pkg::KIND_MEM;
   logic [19:0]           cycle_addr = 20'h00000;
   logic [15:0]           io_addr = 16'h0000;
   logic                  io_wr = 1'b0;
   logic                  io_rd = 1'b0;
   logic [7:0]            io_wdata = 8'h00;
   logic [7:0]            io_rdata;
   logic                  io_rdata_valid;
   logic                  io_hit;
   wait_pkg::bus_state_t  bus_state;
   logic                  wait_state;
   logic                  cycle_end;
   logic                  arm = 1'b0;
   logic [3:0]            low_clocks = 4'h0;
   int                    errors = 0;
   int                    total_checks = 0;

   always #50 clk = ~clk;

   bus_wait_state_control i_bus_wait_state_control
   (
      .clk            (clk),
      .reset_n        (reset_n),
      .ready_pin      (ready_pin),
      .cycle_start    (cycle_start),
      .cycle_kind     (cycle_kind),
      .cycle_addr     (cycle_addr),
      .io_addr        (io_addr),
      .io_wr          (io_wr),
      .io_rd          (io_rd),
      .io_wdata       (io_wdata),
      .io_rdata       (io_rdata),
      .io_rdata_valid (io_rdata_valid),
      .io_hit         (io_hit),
      .bus_state      (bus_state),
      .wait_state     (wait_state),
      .cycle_end      (cycle_end)
   );
   ready_device i_ready_device
   (
      .clk        (clk),
      .reset_n    (reset_n),
      .arm        (arm),
      .low_clocks (low_clocks),
      .ready_pin  (ready_pin)
   );

   task automatic wrap_up();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic chk_reg(logic [8:0] got, logic [8:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("[FAIL] %0t read %h want %h", $time, got, exp);
      end
   endtask
   task automatic chk_waits(int got, int exp);
      total_checks++;
      if (got != exp)
      begin
         errors++;
         $display("[FAIL] %0t waits %0d want %0d", $time, got, exp);
      end
   endtask
   task automatic chk_hit(logic got, logic exp);
      total_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("[FAIL] %0t hit %b want %b", $time, got, exp);
      end
   endtask
   task automatic wr(logic [15:0] a, logic [7:0] d);
      @(posedge clk);
      io_addr  <= a;
      io_wdata <= d;
      io_wr    <= 1'b1;
      @(posedge clk);
      io_wr <= 1'b0;
   endtask
   task automatic rd_chk(logic [15:0] a, logic [7:0] exp, logic h);
      @(posedge clk);
      io_addr <= a;
      io_rd   <= 1'b1;
      @(posedge clk);
      io_rd <= 1'b0;
      #1;
      chk_reg({io_rdata_valid, io_rdata}, {1'b1, exp});
      chk_hit(io_hit, h);
   endtask
   // Armed three clocks early so the second state sees the low level
   task automatic run(wait_pkg::cycle_kind_t k, logic [19:0] a,
                      logic [3:0] lows, int exp);
      int n = 0;
      @(posedge clk);
      arm        <= (lows != 4'h0);
      low_clocks <= lows;
      @(posedge clk);
      arm <= 1'b0;
      repeat (2) @(posedge clk);
      cycle_start <= 1'b1;
      cycle_kind  <= k;
      cycle_addr  <= a;
      @(posedge clk);
      cycle_start <= 1'b0;
      repeat (40)
      begin
         @(posedge clk);
         #1;
         if (wait_state === 1'b1)
            n++;
         if (cycle_end === 1'b1)
            break;
      end
      chk_waits(cycle_end === 1'b1 ? n : -1, exp);
   endtask

   task automatic t_regs();
      logic [15:0] a [8];
      logic [7:0]  r [8];
      logic [7:0]  m [8];
      a = '{wait_pkg::ADDR_AREA, wait_pkg::ADDR_SPLIT, wait_pkg::ADDR_SUB,
            wait_pkg::ADDR_IOB, wait_pkg::ADDR_WCY_A, wait_pkg::ADDR_WCY_C,
            wait_pkg::ADDR_REFRESH_DMA, 16'hffe6};
      r = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'h0f, 8'h00};
      m = '{8'h77, 8'h07, 8'h33, 8'h77, 8'hff, 8'hff, 8'h0f, 8'h00};
      for (int i = 0; i < 8; i++)
         rd_chk(a[i], r[i], i != 7);
      // Unused bits written as zero; the unmapped write must be ignored
      for (int i = 0; i < 8; i++)
      begin
         wr(a[i], (i == 7) ? 8'hff : m[i]);
         rd_chk(a[i], m[i], i != 7);
      end
      rd_chk(wait_pkg::ADDR_STATUS, 8'h80, 1'b1);
   endtask
   task automatic t_refdma();
      for (int i = 0; i < 4; i++)
      begin
         wr(wait_pkg::ADDR_REFRESH_DMA, {4'h0, 2'(i), 2'(3 - i)});
         run(wait_pkg::KIND_REFRESH, 20'h00100, 4'h0, 3 - i);
         run(wait_pkg::KIND_DMA, 20'hfff00, 4'h0, i);
      end
   endtask
   task automatic t_mem();
      wr(wait_pkg::ADDR_AREA, 8'h11);
      wr(wait_pkg::ADDR_WCY_A, 8'h36);
      wr(wait_pkg::ADDR_WCY_C, 8'h46);
      wr(wait_pkg::ADDR_SUB, 8'h00);
      wr(wait_pkg::ADDR_SPLIT, 8'h00);
      run(wait_pkg::KIND_MEM, 20'h00100, 4'h0, 2);
      run(wait_pkg::KIND_MEM, 20'h80000, 4'h0, 1);
      run(wait_pkg::KIND_MEM, 20'hfff00, 4'h0, 3);
      wr(wait_pkg::ADDR_SPLIT, 8'h03);
      run(wait_pkg::KIND_MEM, 20'h00100, 4'h0, 0);
      run(wait_pkg::KIND_MEM, 20'h08000, 4'h0, 2);
      run(wait_pkg::KIND_MEM, 20'hfff00, 4'h0, 1);
      run(wait_pkg::KIND_MEM, 20'hf8000, 4'h0, 3);
   endtask
   task automatic t_io();
      wr(wait_pkg::ADDR_IOB, 8'h00);
      wr(wait_pkg::ADDR_SPLIT, 8'h00);
      run(wait_pkg::KIND_EXT_IO, 20'h00010, 4'h0, 0);
      wr(wait_pkg::ADDR_SPLIT, 8'h04);
      run(wait_pkg::KIND_EXT_IO, 20'h00010, 4'h0, 2);
      run(wait_pkg::KIND_EXT_IO, 20'h0ff80, 4'h0, 1);
      run(wait_pkg::KIND_EXT_IO, 20'h08000, 4'h0, 0);
      run(wait_pkg::KIND_INT_IO, 20'h00010, 4'h6, 0);
   endtask
   task automatic t_ready();
      wr(wait_pkg::ADDR_SPLIT, 8'h00);
      run(wait_pkg::KIND_MEM, 20'h80000, 4'h2, 2);
      run(wait_pkg::KIND_MEM, 20'h80000, 4'h6, 6);
      run(wait_pkg::KIND_MEM, 20'hf8000, 4'h2, 3);
      run(wait_pkg::KIND_EXT_IO, 20'h08000, 4'h2, 2);
      run(wait_pkg::KIND_REFRESH, 20'h00100, 4'h2, 2);
   endtask

   // Runs take a few hundred clocks; this margin is ample
   initial
   begin
      repeat (5000) @(posedge clk);
      errors++;
      $display("[FAIL] %0t watchdog expired", $time);
      wrap_up();
   end
   initial
   begin
      repeat (6) @(posedge clk);
      reset_n <= 1'b1;
      t_regs();
      t_refdma();
      t_mem();
      t_io();
      t_ready();
      wrap_up();
   end
endmodule

bind bus_wait_state_control bus_wait_asserts i_bus_wait_asserts
(
   .clk            (clk),
   .reset_n        (reset_n),
   .ready_pin      (ready_pin),
   .cycle_start    (cycle_start),
   .cycle_kind     (cycle_kind),
   .io_rd          (io_rd),
   .io_rdata_valid (io_rdata_valid),
   .bus_state      (bus_state),
   .wait_state     (wait_state),
   .cycle_end      (cycle_end)
);
`default_nettype wire
